// ==== hdl/rtc_calendar_core.v ====
// rtc_calendar_core.v: bcd real-time clock with calendar, periodic tick, alarm
// and an axi4-lite register slave.
// assumes rtc_src_tick is a one-cycle pulse per 32768 Hz source edge, synchronous to clock,
// and that backup_resetn is only asserted on first battery power-up.
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_clock_map.vh"

// Operation
// (R1) format bit 0 set selects 24-hour counting, clear selects 12-hour.
// (R2) in 12-hour mode time bit 21 marks afternoon.
// (R3) afternoon hour is bcd hour plus 20 hex; noon 32, midnight 12.
// (R4) hour is bcd: 00-23 in 24-hour, 01-12 and 21-32 in 12-hour.
// (R5) day_of_week_value is 3 bits, 0 Sunday to 6 Saturday.
// (R6) 3-bit interval field picks one of eight tick periods.
// (R7) each tick event sets status bit 1.
// (R8) with enable bit 1 set, tick status raises the interrupt request.
// (R9) time and calendar equal to alarm values set status bit 0.
// (R10) alarm status raises the interrupt only with enable bit 0 set.
// (R11) digit mask registers drop chosen digits from the alarm compare.
// (R12) daylight-saving register holds settings and reads back the current mode.
// (R13) time, calendar and both alarm registers are bcd.
// (R14) year is two bcd digits meaning 2000 to 2099.
// (R15) software loads valid digits and a matching day_of_week_value; no checking here.
// (R16) first power-up: compensation 200000 hex, 15/8/8, 24-hour, Saturday, rest zero.
// (R17) unlock, enable and status sit in core domain; others battery-backed. one-hertz output enable is core domain here too.
// (R18) time packs hour, minute and second tens and units digits at fixed bits.
// (R19) bit 3 of each pin control hands its pin to clock or gpio.
// (R20) compensation value scales the source to nominal 32768 Hz via 200000 hex.
// (R21) one-hertz output enable at bit 6 drives 1 Hz from the compensated clock.
// (R22) clock stays in reset until key A5EB1357 written; then active forever.
// (R23) writing A965 unlocks battery writes for 1024 source cycles.
// (R24) interval codes 0 to 7 mean 1/128 second up to one second.
// (R25) counters carry in bcd with month lengths, leap years and day_of_week_value.
// (R26) status flags stay set until software writes one to them.
module rtc_calendar_core #(
	parameter [10:0] UNLOCK_TICKS = `UNLOCK_TICKS
) (
	input  wire                   clock,
	input  wire                   resetn,
	input  wire                   backup_resetn,
	input  wire                   rtc_src_tick,
	input  wire [`AXI_ADDR_W-1:0] awaddr,
	input  wire                   awvalid,
	output wire                   awready,
	input  wire [31:0]            wdata,
	input  wire [3:0]             wstrb,
	input  wire                   wvalid,
	output wire                   wready,
	output wire [1:0]             bresp,
	output wire                   bvalid,
	input  wire                   bready,
	input  wire [`AXI_ADDR_W-1:0] araddr,
	input  wire                   arvalid,
	output wire                   arready,
	output wire [31:0]            rdata,
	output wire [1:0]             rresp,
	output wire                   rvalid,
	input  wire                   rready,
	output wire                   event_irq,
	output wire                   one_hz_out,
	output wire                   crystal_out_owner,
	output wire                   crystal_in_owner,
	output wire                   backup_pin_owner
);

	// battery domain
	reg        active_ff;
	reg [21:0] freq_ff;
	reg [21:0] comp_acc_ff;
	reg [14:0] presc_ff;
	reg [21:0] time_ff;
	reg [23:0] cal_ff;
	reg        fmt_ff;
	reg [2:0]  week_ff;
	reg [21:0] talm_ff;
	reg [23:0] calm_ff;
	reg [2:0]  tick_sel_ff;
	reg [5:0]  tamsk_ff;
	reg [5:0]  camsk_ff;
	reg        xo_own_ff;
	reg        xi_own_ff;
	reg        bk_own_ff;
	reg [2:0]  dst_ff;
	// core domain
	reg        unlock_ff;
	reg [10:0] unlock_cnt_ff;
	reg [1:0]  inten_ff;
	reg [1:0]  sts_ff;
	reg        irq_ff;
	reg        one_hz_en_ff;
	reg        one_hz_ff;
	reg        sec_seen_ff;
	reg        awready_ff;
	reg        wready_ff;
	reg        aw_have_ff;
	reg        w_have_ff;
	reg [`AXI_ADDR_W-1:0] waddr_ff;
	reg [31:0] wdata_ff;
	reg [3:0]  wstrb_ff;
	reg        bvalid_ff;
	reg [1:0]  bresp_ff;
	reg        arready_ff;
	reg        rvalid_ff;
	reg [31:0] rdata_ff;
	reg [1:0]  rresp_ff;

	wire [21:0] step_time;
	wire [23:0] step_cal;
	wire [2:0]  step_week;
	wire        leap;
	wire [31:0] byte_mask;

	clock_step u_step (
		.cur_time  (time_ff),
		.cur_cal   (cal_ff),
		.cur_week  (week_ff),
		.full_day  (fmt_ff),
		.next_time (step_time),
		.next_cal  (step_cal),
		.next_week (step_week),
		.leap_year (leap)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
			assign byte_mask[gi*8+7:gi*8] = {8{wstrb_ff[gi]}};
		end
	endgenerate

	// read view of every register; bit 32 flags a mapped address
	function [32:0] view;
		input [`AXI_ADDR_W-1:0] a;
		begin
			case (a)
				`R_INIT:   view = {1'b1, 31'h0, active_ff}; // (R22)
				`R_UNLOCK: view = {1'b1, 15'h0, unlock_ff, 16'h0}; // (R23)
				`R_FREQ:   view = {1'b1, 10'h0, freq_ff};
				`R_TIME:   view = {1'b1, 10'h0, time_ff}; // (R18)
				`R_CAL:    view = {1'b1, 8'h0, cal_ff};
				`R_CLKFMT: view = {1'b1, 31'h0, fmt_ff};
				`R_WEEK:   view = {1'b1, 29'h0, week_ff};
				`R_TALM:   view = {1'b1, 10'h0, talm_ff};
				`R_CALM:   view = {1'b1, 8'h0, calm_ff};
				`R_LEAP:   view = {1'b1, 31'h0, leap};
				`R_INTEN:  view = {1'b1, 30'h0, inten_ff};
				`R_INTSTS: view = {1'b1, 30'h0, sts_ff};
				`R_TICK:   view = {1'b1, 29'h0, tick_sel_ff};
				`R_TAMSK:  view = {1'b1, 26'h0, tamsk_ff};
				`R_CAMSK:  view = {1'b1, 26'h0, camsk_ff};
				`R_XO_CTL: view = {1'b1, 28'h0, xo_own_ff, 3'h0};
				`R_XI_CTL: view = {1'b1, 28'h0, xi_own_ff, 3'h0};
				`R_BK_CTL: view = {1'b1, 28'h0, bk_own_ff, 3'h0};
				`R_DSTCTL: view = {1'b1, 29'h0, dst_ff}; // (R12)
				`R_CLKOUT: view = {1'b1, 25'h0, one_hz_en_ff, 6'h0};
				default:   view = {1'b0, 32'h0};
			endcase
		end
	endfunction

	wire [32:0] wr_view = view(waddr_ff);
	wire [32:0] rd_view = view(araddr);
	wire [31:0] wd = (wr_view[31:0] & ~byte_mask) | (wdata_ff & byte_mask);
	wire        wr_fire = aw_have_ff & w_have_ff & ~bvalid_ff;
	// battery registers other than the init key register only accept writes inside the unlock window
	wire        bat_we = wr_fire & unlock_ff; // (R23)
	wire        cnt_we = bat_we & active_ff; // (R22)

	// fractional accumulator: adding freq each source edge and taking one compensated
	// edge per 200000 hex keeps the long-run rate nominal; jitter is one source period
	wire        src_on = rtc_src_tick & active_ff;
	wire [22:0] comp_sum = {1'b0, comp_acc_ff} + {1'b0, freq_ff};
	wire        comp_over = comp_sum >= `COMP_ONE; // (R20)
	wire [22:0] comp_left = comp_sum - `COMP_ONE;
	// a slow source leaves a whole tick in the accumulator; it drains on an idle cycle,
	// so compensation works both ways as long as source edges are not back to back
	wire        comp_spare = active_ff & ~rtc_src_tick & ({1'b0, comp_acc_ff} >= `COMP_ONE);
	wire [22:0] comp_drain = {1'b0, comp_acc_ff} - `COMP_ONE;
	wire        comp_tick = (src_on & comp_over) | comp_spare;
	wire        sec_pulse = comp_tick & (presc_ff == `PRESC_TOP);
	wire [15:0] tick_lim = (`TICK_BASE << tick_sel_ff) - 16'h0001; // (R24)
	wire        tick_evt = comp_tick & ((presc_ff & tick_lim[14:0]) == tick_lim[14:0]); // (R6)

	// digit masks widened to the bcd field layout
	wire [21:0] tmask_bits = {{2{tamsk_ff[5]}}, {4{tamsk_ff[4]}}, 1'b0, {3{tamsk_ff[3]}},
		{4{tamsk_ff[2]}}, 1'b0, {3{tamsk_ff[1]}}, {4{tamsk_ff[0]}}};
	wire [23:0] cmask_bits = {{4{camsk_ff[5]}}, {4{camsk_ff[4]}}, 3'h0, camsk_ff[3],
		{4{camsk_ff[2]}}, 2'h0, {2{camsk_ff[1]}}, {4{camsk_ff[0]}}};
	wire        alarm_match = (((time_ff ^ talm_ff) & ~tmask_bits) == 22'h0) &&
		(((cal_ff ^ calm_ff) & ~cmask_bits) == 24'h0); // (R11)
	wire [1:0]  sts_set = {tick_evt, sec_seen_ff & alarm_match}; // (R7) (R9)
	// write-one-clear takes raw data: the merged read value would clear unstrobed flags
	wire [1:0]  sts_clr = (wr_fire && waddr_ff == `R_INTSTS) ?
		(wdata_ff[1:0] & {2{wstrb_ff[0]}}) : 2'h0;

	// battery domain: kept across core resets
	always @(posedge clock or negedge backup_resetn) begin // (R17)
		if (!backup_resetn) begin // (R16)
			active_ff <= 1'b0;
			freq_ff <= `FREQ_RST;
			comp_acc_ff <= 22'h0;
			presc_ff <= 15'h0;
			time_ff <= 22'h0;
			cal_ff <= `CAL_RST;
			fmt_ff <= `FMT_RST;
			week_ff <= `WEEK_RST;
			talm_ff <= 22'h0;
			calm_ff <= 24'h0;
			tick_sel_ff <= 3'h0;
			tamsk_ff <= 6'h0;
			camsk_ff <= 6'h0;
			xo_own_ff <= 1'b0;
			xi_own_ff <= 1'b0;
			bk_own_ff <= 1'b0;
			dst_ff <= 3'h0;
		end else begin
			if (wr_fire && waddr_ff == `R_INIT && wd == `ACT_KEY)
				active_ff <= 1'b1; // (R22)
			if (src_on)
				comp_acc_ff <= comp_over ? comp_left[21:0] : comp_sum[21:0];
			else if (comp_spare)
				comp_acc_ff <= comp_drain[21:0];
			if (comp_tick)
				presc_ff <= presc_ff + 15'h0001;
			if (sec_pulse) begin // (R25)
				time_ff <= step_time;
				cal_ff <= step_cal;
				week_ff <= step_week;
			end
			// a register write in the same cycle as a carry wins
			if (bat_we) begin
				case (waddr_ff)
					`R_FREQ:   freq_ff <= wd[21:0];
					`R_XO_CTL: xo_own_ff <= wd[`OWNER_BIT]; // (R19)
					`R_XI_CTL: xi_own_ff <= wd[`OWNER_BIT]; // (R19)
					`R_BK_CTL: bk_own_ff <= wd[`OWNER_BIT]; // (R19)
					default: ;
				endcase
			end
			if (cnt_we) begin
				case (waddr_ff)
					`R_TIME:   time_ff <= wd[21:0]; // (R13)
					`R_CAL:    cal_ff <= wd[23:0]; // (R14)
					`R_CLKFMT: fmt_ff <= wd[`SCALE_BIT]; // (R1)
					`R_WEEK:   week_ff <= wd[2:0]; // (R5)
					`R_TALM:   talm_ff <= wd[21:0];
					`R_CALM:   calm_ff <= wd[23:0];
					`R_TICK:   tick_sel_ff <= wd[2:0];
					`R_TAMSK:  tamsk_ff <= wd[5:0];
					`R_CAMSK:  camsk_ff <= wd[5:0];
					`R_DSTCTL: dst_ff <= wd[2:0]; // (R12)
					default: ;
				endcase
			end
		end
	end

	// core domain: unlock window, interrupt logic, 1 Hz pin and bus slave
	always @(posedge clock or negedge resetn) begin // (R17)
		if (!resetn) begin
			unlock_ff <= 1'b0;
			unlock_cnt_ff <= 11'h0;
			inten_ff <= 2'h0;
			sts_ff <= 2'h0;
			irq_ff <= 1'b0;
			one_hz_en_ff <= 1'b0;
			one_hz_ff <= 1'b0;
			sec_seen_ff <= 1'b0;
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			waddr_ff <= {`AXI_ADDR_W{1'b0}};
			wdata_ff <= 32'h0;
			wstrb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `RESP_OKAY;
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0;
			rresp_ff <= `RESP_OKAY;
		end else begin
			// a repeated key restarts the window, so it always lasts the full count
			if (wr_fire && waddr_ff == `R_UNLOCK && wd[15:0] == `UNLOCK_KEY) begin // (R23)
				unlock_ff <= 1'b1;
				unlock_cnt_ff <= 11'h0;
			end else if (unlock_ff && rtc_src_tick) begin
				if (unlock_cnt_ff == UNLOCK_TICKS - 11'h001)
					unlock_ff <= 1'b0;
				else
					unlock_cnt_ff <= unlock_cnt_ff + 11'h001;
			end
			if (wr_fire && waddr_ff == `R_INTEN)
				inten_ff <= wd[1:0];
			if (wr_fire && waddr_ff == `R_CLKOUT)
				one_hz_en_ff <= wd[`ONE_HZ_BIT];
			sec_seen_ff <= sec_pulse;
			sts_ff <= (sts_ff & ~sts_clr) | sts_set; // (R26)
			irq_ff <= |(sts_ff & inten_ff); // (R8) (R10)
			one_hz_ff <= one_hz_en_ff & presc_ff[`ONE_HZ_TAP]; // (R21)
			if (awvalid && awready_ff) begin
				waddr_ff <= awaddr;
				aw_have_ff <= 1'b1;
				awready_ff <= 1'b0;
			end
			if (wvalid && wready_ff) begin
				wdata_ff <= wdata;
				wstrb_ff <= wstrb;
				w_have_ff <= 1'b1;
				wready_ff <= 1'b0;
			end
			if (wr_fire) begin
				aw_have_ff <= 1'b0;
				w_have_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_view[32] ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bvalid_ff && bready) begin
				bvalid_ff <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff <= 1'b1;
			end
			if (arvalid && arready_ff) begin
				arready_ff <= 1'b0;
				rvalid_ff <= 1'b1;
				rdata_ff <= rd_view[31:0];
				rresp_ff <= rd_view[32] ? `RESP_OKAY : `RESP_SLVERR;
			end else if (rvalid_ff && rready) begin
				rvalid_ff <= 1'b0;
				arready_ff <= 1'b1;
			end
		end
	end

	assign awready = awready_ff;
	assign wready = wready_ff;
	assign bresp = bresp_ff;
	assign bvalid = bvalid_ff;
	assign arready = arready_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;
	assign rvalid = rvalid_ff;
	assign event_irq = irq_ff;
	assign one_hz_out = one_hz_ff;
	assign crystal_out_owner = xo_own_ff;
	assign crystal_in_owner = xi_own_ff;
	assign backup_pin_owner = bk_own_ff;

endmodule // rtc_calendar_core
`default_nettype wire

// ==== inc/rtc_clock_map.vh ====
// rtc_clock_map.vh: register offsets, field positions, keys and reset values
// of the bcd calendar clock. definitions only, included by every design file.
`ifndef RTC_CLOCK_MAP_VH
`define RTC_CLOCK_MAP_VH

`define AXI_ADDR_W    12
`define R_INIT        12'h000
`define R_UNLOCK      12'h004
`define R_FREQ        12'h008
`define R_TIME        12'h00C
`define R_CAL         12'h010
`define R_CLKFMT      12'h014
`define R_WEEK        12'h018
`define R_TALM        12'h01C
`define R_CALM        12'h020
`define R_LEAP        12'h024
`define R_INTEN       12'h028
`define R_INTSTS      12'h02C
`define R_TICK        12'h030
`define R_TAMSK       12'h034
`define R_CAMSK       12'h038
`define R_XO_CTL      12'h104
`define R_XI_CTL      12'h108
`define R_BK_CTL      12'h10C
`define R_DSTCTL      12'h110
`define R_CLKOUT      12'h120

`define ACT_KEY       32'hA5EB1357
`define UNLOCK_KEY    16'hA965
`define UNLOCK_TICKS  11'h400
`define UNLOCKF_BIT   16
`define SCALE_BIT     0
`define ALM_BIT       0
`define TICK_BIT      1
`define OWNER_BIT     3
`define ONE_HZ_BIT    6

`define FREQ_RST      22'h200000
`define COMP_ONE      23'h200000
`define CAL_RST       24'h150808
`define FMT_RST       1'h1
`define WEEK_RST      3'h6
`define SATURDAY      3'h6
`define TICK_BASE     16'h0100
`define PRESC_TOP     15'h7FFF
`define ONE_HZ_TAP    14

`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// ==== hdl/clock_step.v ====
// clock_step.v: combinational next-second value of bcd time, calendar and day_of_week_value.
// assumes loaded digits are valid bcd; invalid loads give undefined but harmless counts.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_clock_map.vh"

module clock_step (
	input  wire [21:0] cur_time,
	input  wire [23:0] cur_cal,
	input  wire [2:0]  cur_week,
	input  wire        full_day,
	output reg  [21:0] next_time,
	output reg  [23:0] next_cal,
	output reg  [2:0]  next_week,
	output reg         leap_year
);

	reg [7:0] secs;
	reg [7:0] mnt;
	reg [7:0] hour;
	reg [7:0] day;
	reg [7:0] mon;
	reg [7:0] yr;
	reg [7:0] last;
	reg       roll;
	reg       pm;

	function [7:0] bcd_inc;
		input [7:0] v;
		begin
			if (v[3:0] == 4'h9)
				bcd_inc = {v[7:4] + 4'h1, 4'h0};
			else
				bcd_inc = v + 8'h01;
		end
	endfunction

	always @* begin
		secs = {1'b0, cur_time[6:0]};
		mnt = {1'b0, cur_time[14:8]};
		hour = {2'h0, cur_time[21:16]};
		yr = cur_cal[23:16];
		mon = {3'h0, cur_cal[12:8]};
		day = {2'h0, cur_cal[5:0]};
		next_time = cur_time;
		next_cal = cur_cal;
		next_week = cur_week;
		roll = 1'b0;
		pm = hour[5];
		// years 2000..2099: every fourth is leap, 2000 included
		if (yr[4])
			leap_year = (yr[3:0] == 4'h2) || (yr[3:0] == 4'h6);
		else
			leap_year = (yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) || (yr[3:0] == 4'h8);
		case (mon)
			8'h02: last = leap_year ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: last = 8'h30;
			default: last = 8'h31;
		endcase
		if (secs == 8'h59) begin // (R25)
			next_time[6:0] = 7'h00;
			if (mnt == 8'h59) begin
				next_time[14:8] = 7'h00;
				if (full_day) begin // (R1)
					if (hour == 8'h23) begin // (R4)
						hour = 8'h00;
						roll = 1'b1;
					end else begin
						hour = bcd_inc(hour);
					end
				end else begin
					// afternoon is the hour plus 20 hex; 11 pm rolls to 12 am and a new day
					hour[5] = 1'b0; // (R2)
					if (hour == 8'h12) begin
						hour = 8'h01;
					end else if (hour == 8'h11) begin // (R3)
						hour = 8'h12;
						roll = pm;
						pm = ~pm;
					end else begin
						hour = bcd_inc(hour);
					end
					hour[5] = pm;
				end
				next_time[21:16] = hour[5:0];
			end else begin
				mnt = bcd_inc(mnt);
				next_time[14:8] = mnt[6:0];
			end
		end else begin
			secs = bcd_inc(secs);
			next_time[6:0] = secs[6:0];
		end
		if (roll) begin
			next_week = (cur_week == `SATURDAY) ? 3'h0 : cur_week + 3'h1; // (R5)
			if (day == last) begin
				day = 8'h01;
				if (mon == 8'h12) begin
					mon = 8'h01;
					yr = (yr == 8'h99) ? 8'h00 : bcd_inc(yr); // (R14)
				end else begin
					mon = bcd_inc(mon);
				end
			end else begin
				day = bcd_inc(day);
			end
			next_cal = {yr, 3'h0, mon[4:0], 2'h0, day[5:0]};
		end
	end

endmodule // clock_step
`default_nettype wire

// ==== testbench/rtc_calendar_core_properties.sv ====
// rtc_calendar_core_properties.sv: port-level checks for the bcd calendar clock core.
// assumes write address and write data are offered together with full byte strobes.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_clock_map.vh"

module rtc_calendar_core_properties (
	input wire logic                   clock,
	input wire logic                   resetn,
	input wire logic [`AXI_ADDR_W-1:0] awaddr,
	input wire logic                   awvalid,
	input wire logic                   awready,
	input wire logic [31:0]            wdata,
	input wire logic                   wvalid,
	input wire logic                   wready,
	input wire logic                   bvalid,
	input wire logic                   bready,
	input wire logic [`AXI_ADDR_W-1:0] araddr,
	input wire logic                   arvalid,
	input wire logic                   arready,
	input wire logic [31:0]            rdata,
	input wire logic [1:0]             rresp,
	input wire logic                   rvalid,
	input wire logic                   rready,
	input wire logic                   event_irq,
	input wire logic                   one_hz_out,
	input wire logic                   crystal_out_owner,
	input wire logic                   crystal_in_owner,
	input wire logic                   backup_pin_owner
);
	localparam logic [`AXI_ADDR_W-1:0] HOLE = 12'h200;
	logic       wr_fire;
	logic       pin_fire;
	logic [1:0] inten_ff;
	logic       clkout_ff;

	assign wr_fire  = awvalid && awready && wvalid && wready;
	assign pin_fire = wr_fire && (awaddr == `R_XO_CTL || awaddr == `R_XI_CTL
		|| awaddr == `R_BK_CTL);

	// shadow of what software last wrote; a few cycles of slack cover write latency
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			inten_ff  <= 2'h0;
			clkout_ff <= 1'h0;
		end else if (wr_fire) begin
			if (awaddr == `R_INTEN)
				inten_ff <= wdata[1:0];
			if (awaddr == `R_CLKOUT)
				clkout_ff <= wdata[6];
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	AST_IRQ_QUIET: assert property (
		(inten_ff | $past(inten_ff) | $past(inten_ff, 2) | $past(inten_ff, 3)) == 2'h0
		|-> !event_irq) else $error("interrupt raised with both enables clear");
	AST_ONE_HZ_IDLE: assert property (
		!(clkout_ff || $past(clkout_ff) || $past(clkout_ff, 2) || $past(clkout_ff, 3))
		|-> !one_hz_out) else $error("one hertz output active while disabled");
	AST_OWNER_CAUSE: assert property (
		$changed({crystal_out_owner, crystal_in_owner, backup_pin_owner})
		|-> $past(pin_fire) || $past(pin_fire, 2) || $past(pin_fire, 3))
		else $error("pin owner changed without a pin control write");
	AST_WRITE_ANSWER: assert property (wr_fire |-> ##[1:2] bvalid)
		else $error("write response late");
	AST_WRITE_BUSY: assert property (bvalid |-> !awready && !wready)
		else $error("write channels ready during response");
	AST_B_RELEASE: assert property (bvalid && bready |=> !bvalid)
		else $error("write response held after handshake");
	AST_READ_ANSWER: assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	AST_READ_BUSY: assert property (rvalid |-> !arready)
		else $error("read address ready during data phase");
	AST_R_RELEASE: assert property (rvalid && rready |=> !rvalid && arready)
		else $error("read channel not released");
	AST_HOLE_READ: assert property (arvalid && arready && araddr == HOLE
		|=> rresp == `RESP_SLVERR && rdata == 32'h0) else $error("unmapped read answered");

	COV_IRQ: cover property (event_irq);
	COV_HOLE: cover property (rvalid && rresp == `RESP_SLVERR);
	COV_OWNER: cover property ($rose(crystal_out_owner));
endmodule // rtc_calendar_core_properties

`default_nettype wire

// ==== testbench/test_rtc_calendar_core.sv ====
// test_rtc_calendar_core.sv: self-checking bench for the bcd calendar clock core.
// assumes the core answers the register bus at its own pace; source ticks come from here.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_clock_map.vh"

`define CHK(got, exp) \
	begin check_count++; if ((got) !== (exp)) begin num_errors++; \
	$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end

module test_rtc_calendar_core;
	logic        clock, resetn, backup_resetn, rtc_src_tick;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd_data;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, event_irq, one_hz_out;
	logic        crystal_out_owner, crystal_in_owner, backup_pin_owner;
	int          num_errors = 0;
	int          check_count = 0;
	localparam logic [43:0] DFLT [0:7] = '{{`R_INIT, 32'h0}, {`R_FREQ, 32'h200000},
		{`R_TIME, 32'h0}, {`R_CAL, 32'h150808}, {`R_CLKFMT, 32'h1}, {`R_WEEK, 32'h6},
		{`R_INTSTS, 32'h0}, {`R_DSTCTL, 32'h0}};

	// short unlock window so expiry is reached in a few source ticks
	rtc_calendar_core #(.UNLOCK_TICKS(11'h004)) u_dut (
		.clock(clock), .resetn(resetn), .backup_resetn(backup_resetn),
		.rtc_src_tick(rtc_src_tick), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.event_irq(event_irq), .one_hz_out(one_hz_out),
		.crystal_out_owner(crystal_out_owner), .crystal_in_owner(crystal_in_owner),
		.backup_pin_owner(backup_pin_owner));

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		do begin
			@(posedge clock);
			if (awready === 1'h1)
				awvalid <= 1'h0;
			if (wready === 1'h1)
				wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		// bready stays up between writes so no time step drives it twice
		resp = bresp;
	endtask

	task automatic axi_rd(input logic [11:0] a);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do begin
			@(posedge clock);
			if (arready === 1'h1)
				arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		rd_data = rdata;
		resp = rresp;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		axi_rd(a);
		`CHK(rd_data, e)
	endtask

	task automatic run_ticks(input int n);
		rtc_src_tick <= 1'h1;
		repeat (n) @(posedge clock);
		rtc_src_tick <= 1'h0;
	endtask

	task unlock;
		axi_wr(`R_UNLOCK, 32'h0000A965);
	endtask

	task reset_defaults;
		for (int i = 0; i < 8; i++)
			rd_chk(DFLT[i][43:32], DFLT[i][31:0]);
	endtask

	task activate_and_lock;
		axi_wr(`R_FREQ, 32'h100000);
		rd_chk(`R_FREQ, 32'h200000);
		unlock();
		axi_rd(`R_UNLOCK);
		`CHK(rd_data[16], 1'h1)
		axi_wr(`R_TIME, 32'h010203);
		rd_chk(`R_TIME, 32'h0);
		axi_wr(`R_INIT, 32'h12345678);
		rd_chk(`R_INIT, 32'h0);
		axi_wr(`R_INIT, `ACT_KEY);
		rd_chk(`R_INIT, 32'h1);
		axi_wr(`R_TIME, 32'h010203);
		rd_chk(`R_TIME, 32'h010203);
		run_ticks(5);
		axi_rd(`R_UNLOCK);
		`CHK(rd_data[16], 1'h0)
		axi_wr(`R_TIME, 32'h0);
		rd_chk(`R_TIME, 32'h010203);
	endtask

	// ticks stay off during register setup so the unlock window survives it
	task noon_alarm_and_irq;
		unlock();
		axi_wr(`R_CLKFMT, 32'h0);
		axi_wr(`R_TIME, 32'h115959);
		axi_wr(`R_TALM, 32'h320000);
		axi_wr(`R_CALM, 32'h150808);
		axi_wr(`R_TICK, 32'h7);
		axi_wr(`R_INTEN, 32'h1);
		run_ticks(32770);
		rd_chk(`R_TIME, 32'h320000);
		rd_chk(`R_INTSTS, 32'h3);
		`CHK(event_irq, 1'h1)
		axi_wr(`R_INTSTS, 32'h1);
		rd_chk(`R_INTSTS, 32'h2);
		`CHK(event_irq, 1'h0)
		axi_wr(`R_INTEN, 32'h2);
		axi_rd(`R_INTEN);
		`CHK(event_irq, 1'h1)
		axi_wr(`R_INTSTS, 32'h2);
	endtask

	task tick_intervals;
		unlock();
		axi_wr(`R_TICK, 32'h6);
		run_ticks(300);
		rd_chk(`R_INTSTS, 32'h0);
		unlock();
		axi_wr(`R_TICK, 32'h0);
		run_ticks(300);
		rd_chk(`R_INTSTS, 32'h2);
		axi_wr(`R_INTSTS, 32'h2);
	endtask

	task year_rollover;
		unlock();
		axi_wr(`R_CLKFMT, 32'h1);
		axi_wr(`R_TIME, 32'h235959);
		// a saturday year end into a leap year: every carry and the day_of_week_value wrap
		axi_wr(`R_CAL, 32'h391231);
		axi_wr(`R_WEEK, 32'h6);
		axi_wr(`R_TALM, 32'h30);
		axi_wr(`R_TAMSK, 32'h2);
		axi_wr(`R_CAMSK, 32'h3F);
		axi_wr(`R_TICK, 32'h7);
		run_ticks(32770);
		rd_chk(`R_TIME, 32'h0);
		rd_chk(`R_CAL, 32'h400101);
		rd_chk(`R_WEEK, 32'h0);
		rd_chk(`R_LEAP, 32'h1);
		rd_chk(`R_INTSTS, 32'h3);
	endtask

	task pins_and_holes;
		logic hz0;
		unlock();
		axi_wr(`R_XO_CTL, 32'h8);
		axi_wr(`R_XI_CTL, 32'h8);
		axi_wr(`R_BK_CTL, 32'h8);
		axi_wr(`R_DSTCTL, 32'h4);
		axi_wr(`R_CLKOUT, 32'h40);
		`CHK({crystal_out_owner, crystal_in_owner, backup_pin_owner}, 3'h7)
		rd_chk(`R_DSTCTL, 32'h4);
		axi_wr(12'h200, 32'h1);
		`CHK(resp, `RESP_SLVERR)
		rd_chk(12'h200, 32'h0);
		`CHK(resp, `RESP_SLVERR)
		hz0 = one_hz_out;
		run_ticks(16400);
		`CHK(one_hz_out, ~hz0)
	endtask

	task give_verdict;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		clock = 1'h0;
		forever #20 clock = ~clock;
	end

	initial begin
		{resetn, backup_resetn, rtc_src_tick} = 3'h0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		awaddr = 12'h0;
		araddr = 12'h0;
		wdata = 32'h0;
		wstrb = 4'hF;
		repeat (12) @(posedge clock);
		{resetn, backup_resetn} <= 2'h3;
		@(posedge clock);
		reset_defaults();
		activate_and_lock();
		noon_alarm_and_irq();
		tick_intervals();
		year_rollover();
		pins_and_holes();
		give_verdict();
	end

	// the two one-second runs dominate; this leaves headroom above them
	initial begin
		repeat (95000) @(posedge clock);
		num_errors++;
		give_verdict();
	end
endmodule // test_rtc_calendar_core

bind rtc_calendar_core rtc_calendar_core_properties u_props (
	.clock(clock), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
	.awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
	.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
	.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
	.event_irq(event_irq), .one_hz_out(one_hz_out),
	.crystal_out_owner(crystal_out_owner), .crystal_in_owner(crystal_in_owner),
	.backup_pin_owner(backup_pin_owner));

`default_nettype wire
